// ==== stm_pkg.sv ====
// Purpose: Constants of the standard timer control and compare-match block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Register offsets are local choices
// Contract
// [RL1] Run rising edge clears counter
// [RL2] Run falling edge stops, holds count
// [RL3] Run rising edge restores initial pin level
// [RL4] Control bits two to zero read zero
// [RL5] Mode field selects four modes
// [RL6] Software stops timer before mode change
// [RL7] Timer/counter mode releases output pin
// [RL8] Compare mode A match acts on pin
// [RL9] PWM mode pin function selects waveform
// [RL10] Capture mode pin function selects edge
// [RL11] Software changes PWM function only stopped
// [RL12] Match equal to initial level: no change
// [RL13] Initial level bit sets level or active
// [RL14] Invert bit inverts output pin
// [RL15] Swap bit exchanges period and duty roles
// [RL16] Clear source picks A or P clear
// [RL17] Overflow clear only when period zero
// [RL18] Clear source ignored outside compare modes
// [RL19] Period value compared with counter high byte
// [RL20] Clear source low raises both flags
// [RL21] Clear source high raises only A flag
// [RL22] Software never sets compare A zero
// [RL23] Only A matches change the pin
// [RL24] Pause holds count, stays powered
// [RL25] Clock source field selects tick source
// [RL26] Counter increments once per selected tick
package stm_pkg;
  localparam logic [11:0] STM_OFS_CTRL0  = 12'h000;
  localparam logic [11:0] STM_OFS_CTRL1  = 12'h004;
  localparam logic [11:0] STM_OFS_PERIOD = 12'h008;
  localparam logic [11:0] STM_OFS_CMPA   = 12'h00C;
  localparam logic [11:0] STM_OFS_COUNT  = 12'h010;
  localparam logic [11:0] STM_OFS_FLAGS  = 12'h014;
  localparam int STM_C0_PAUSE = 7;
  localparam int STM_C0_CKLO  = 4;
  localparam int STM_C0_RUN   = 3;
  localparam int STM_C1_MODELO = 6;
  localparam int STM_C1_PFLO   = 4;
  localparam int STM_C1_INIT   = 3;
  localparam int STM_C1_INV    = 2;
  localparam int STM_C1_SWAP   = 1;
  localparam int STM_C1_CLRSRC = 0;
  localparam logic [7:0]  STM_RST_CTRL0  = 8'h00;
  localparam logic [7:0]  STM_RST_CTRL1  = 8'h00;
  localparam logic [7:0]  STM_RST_PERIOD = 8'h00;
  localparam logic [15:0] STM_RST_CMPA   = 16'h0000;
  localparam logic [7:0]  STM_C0_MASK    = 8'hF8;
  localparam logic [1:0] STM_MODE_CMP  = 2'h0;
  localparam logic [1:0] STM_MODE_CAP  = 2'h1;
  localparam logic [1:0] STM_MODE_PWM  = 2'h2;
  localparam logic [1:0] STM_MODE_TMR  = 2'h3;
  localparam logic [1:0] STM_PF_0 = 2'h0;
  localparam logic [1:0] STM_PF_1 = 2'h1;
  localparam logic [1:0] STM_PF_2 = 2'h2;
  localparam logic [1:0] STM_PF_3 = 2'h3;
  localparam logic [2:0] STM_CK_SYS4  = 3'h0;
  localparam logic [2:0] STM_CK_SYS   = 3'h1;
  localparam logic [2:0] STM_CK_H16   = 3'h2;
  localparam logic [2:0] STM_CK_H64   = 3'h3;
  localparam logic [2:0] STM_CK_SUBA  = 3'h4;
  localparam logic [2:0] STM_CK_SUBB  = 3'h5;
  localparam logic [2:0] STM_CK_EXTR  = 3'h6;
  localparam logic [2:0] STM_CK_EXTF  = 3'h7;
  localparam logic [5:0] STM_DIV4  = 6'h03;
  localparam logic [5:0] STM_DIV16 = 6'h0F;
  localparam logic [5:0] STM_DIV64 = 6'h3F;
endpackage : stm_pkg

// ==== stm_timer.sv ====
// Purpose: Control, counter and compare-match logic of a 16-bit timer
// Assumes: APB slave on clk_in; pins sampled through three flip-flops
// Notes:   High-speed and sub clocks arrive as tick inputs on clk_in
`timescale 1ns/1ps
module stm_timer
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        hs_tick_in,
  input  wire logic        sub_tick_in,
  input  wire logic        ext_clk_pin_in,
  input  wire logic        capture_input_pin_in,
  output logic             timer_output_pin_out,
  output logic             timer_output_pin_oe_out,
  output logic             compare_a_match_flag_out,
  output logic             compare_p_match_flag_out
);

  logic [7:0]  ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, period_q, period_d;
  logic [15:0] cmpa_q, cmpa_d, count_q, count_d;
  logic        flag_a_q, flag_a_d, flag_p_q, flag_p_d;
  logic        out_q, out_d, run_prev_q, run_prev_d;
  logic [5:0]  div_q, div_d, hdiv_q, hdiv_d;
  logic [2:0]  ext_sync_q, cap_sync_q;
  logic        ext_lvl_q, cap_lvl_q, ext_lvl_d, cap_lvl_d;
  logic [31:0] rdata_q, rdata_d;

  logic        wr, rd, run, pause, tick, run_rise;
  logic        match_a, match_p, ovf, clr_cnt, cap_ev, ext_rise, ext_fall;
  logic [1:0]  mode, pf;
  logic [2:0]  cksel;
  logic        pwm_lvl, duty_hit;
  logic        map_hit;

  function automatic logic sel_addr(input logic [11:0] a, input logic [11:0] ofs);
    sel_addr = (a == ofs);
  endfunction : sel_addr

  assign wr       = psel_in && penable_in && pwrite_in && ce_in;
  assign rd       = psel_in && !penable_in && !pwrite_in;
  assign run      = ctrl0_q[stm_pkg::STM_C0_RUN];
  assign pause    = ctrl0_q[stm_pkg::STM_C0_PAUSE];
  assign cksel    = ctrl0_q[stm_pkg::STM_C0_CKLO +: 3];
  // [RL5] Mode field decode
  assign mode     = ctrl1_q[stm_pkg::STM_C1_MODELO +: 2];
  assign pf       = ctrl1_q[stm_pkg::STM_C1_PFLO +: 2];
  assign run_rise = run && !run_prev_q;
  assign ext_rise = ext_lvl_d && !ext_lvl_q;
  assign ext_fall = !ext_lvl_d && ext_lvl_q;
  assign map_hit  = sel_addr(paddr_in, stm_pkg::STM_OFS_CTRL0)
                 || sel_addr(paddr_in, stm_pkg::STM_OFS_CTRL1)
                 || sel_addr(paddr_in, stm_pkg::STM_OFS_PERIOD)
                 || sel_addr(paddr_in, stm_pkg::STM_OFS_CMPA)
                 || sel_addr(paddr_in, stm_pkg::STM_OFS_COUNT)
                 || sel_addr(paddr_in, stm_pkg::STM_OFS_FLAGS);
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !map_hit;
  assign prdata_out  = rdata_q;

  // Pin synchronisers: second and third stages must agree
  always_comb
  begin
    ext_lvl_d = (ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[1] : ext_lvl_q;
    cap_lvl_d = (cap_sync_q[1] == cap_sync_q[2]) ? cap_sync_q[1] : cap_lvl_q;
  end

  // [RL25] Tick source select
  always_comb
  begin
    div_d  = div_q + 6'h01;
    hdiv_d = hs_tick_in ? hdiv_q + 6'h01 : hdiv_q;
    case (cksel)
      stm_pkg::STM_CK_SYS4:  tick = (div_q[1:0] == stm_pkg::STM_DIV4[1:0]);
      stm_pkg::STM_CK_SYS:   tick = 1'b1;
      stm_pkg::STM_CK_H16:   tick = hs_tick_in && (hdiv_q[3:0] == stm_pkg::STM_DIV16[3:0]);
      stm_pkg::STM_CK_H64:   tick = hs_tick_in && (hdiv_q == stm_pkg::STM_DIV64);
      stm_pkg::STM_CK_SUBA,
      stm_pkg::STM_CK_SUBB:  tick = sub_tick_in;
      stm_pkg::STM_CK_EXTR:  tick = ext_rise;
      stm_pkg::STM_CK_EXTF:  tick = ext_fall;
      default:               tick = 1'b0;
    endcase
  end

  // [RL19] Period compared with counter high byte; zero means full wrap
  assign match_p = (count_q[15:8] == period_q) && (period_q != 8'h00)
                && (count_q[7:0] == 8'h00) && run_prev_q;
  // [RL17] Overflow clear only with period bits all zero
  assign ovf     = (period_q == 8'h00) && (count_q == 16'hFFFF) && tick;
  assign match_a = (count_q == cmpa_q) && run_prev_q;

  always_comb
  begin
    cap_ev = 1'b0;
    // [RL10] Capture edge select
    case (pf)
      stm_pkg::STM_PF_0: cap_ev = cap_lvl_d && !cap_lvl_q;
      stm_pkg::STM_PF_1: cap_ev = !cap_lvl_d && cap_lvl_q;
      stm_pkg::STM_PF_2: cap_ev = cap_lvl_d != cap_lvl_q;
      default:           cap_ev = 1'b0;
    endcase
    cap_ev = cap_ev && (mode == stm_pkg::STM_MODE_CAP) && run;
  end

  always_comb
  begin
    clr_cnt = 1'b0;
    // [RL16] [RL18] Clear source by mode
    case (mode)
      stm_pkg::STM_MODE_CMP,
      stm_pkg::STM_MODE_TMR:
        clr_cnt = ctrl1_q[stm_pkg::STM_C1_CLRSRC] ? match_a : match_p;
      stm_pkg::STM_MODE_CAP:
        clr_cnt = match_p;
      stm_pkg::STM_MODE_PWM:
        // [RL15] Period comparator chosen by swap bit
        clr_cnt = ctrl1_q[stm_pkg::STM_C1_SWAP] ? match_a : match_p;
      default:
        clr_cnt = 1'b0;
    endcase
  end

  // PWM active level: duty reached ends active phase
  always_comb
  begin
    duty_hit = ctrl1_q[stm_pkg::STM_C1_SWAP]
             ? ((period_q != 8'h00) && (count_q[15:8] >= period_q))
             : (count_q >= cmpa_q);
    // [RL9] Waveform by pin function
    case (pf)
      stm_pkg::STM_PF_0: pwm_lvl = 1'b0;
      stm_pkg::STM_PF_1: pwm_lvl = 1'b1;
      stm_pkg::STM_PF_2: pwm_lvl = run && !duty_hit;
      stm_pkg::STM_PF_3: pwm_lvl = run;
      default:           pwm_lvl = 1'b0;
    endcase
  end

  always_comb
  begin
    ctrl0_d    = ctrl0_q;
    ctrl1_d    = ctrl1_q;
    period_d   = period_q;
    cmpa_d     = cmpa_q;
    count_d    = count_q;
    flag_a_d   = flag_a_q;
    flag_p_d   = flag_p_q;
    out_d      = out_q;
    run_prev_d = run;
    rdata_d    = rdata_q;
    if (rd)
    begin
      rdata_d = 32'h0000_0000;
      // [RL4] Low control bits read zero
      if (sel_addr(paddr_in, stm_pkg::STM_OFS_CTRL0))  rdata_d[7:0] = ctrl0_q & stm_pkg::STM_C0_MASK;
      if (sel_addr(paddr_in, stm_pkg::STM_OFS_CTRL1))  rdata_d[7:0] = ctrl1_q;
      if (sel_addr(paddr_in, stm_pkg::STM_OFS_PERIOD)) rdata_d[7:0] = period_q;
      if (sel_addr(paddr_in, stm_pkg::STM_OFS_CMPA))   rdata_d[15:0] = cmpa_q;
      if (sel_addr(paddr_in, stm_pkg::STM_OFS_COUNT))  rdata_d[15:0] = count_q;
      if (sel_addr(paddr_in, stm_pkg::STM_OFS_FLAGS))  rdata_d[1:0] = {flag_p_q, flag_a_q};
    end
    // [RL1] [RL2] [RL24] [RL26] Counter control
    if (run_rise)
      count_d = 16'h0000;
    else if (run && run_prev_q && !pause && tick)
      count_d = clr_cnt || ovf ? 16'h0000 : count_q + 16'h0001;
    else if (run && run_prev_q && !pause && clr_cnt && mode != stm_pkg::STM_MODE_PWM)
      count_d = count_q;
    // Flag clear by writing one; a new event wins
    if (wr && sel_addr(paddr_in, stm_pkg::STM_OFS_FLAGS))
    begin
      if (pwdata_in[0]) flag_a_d = 1'b0;
      if (pwdata_in[1]) flag_p_d = 1'b0;
    end
    if (run && tick && !pause)
    begin
      // [RL20] [RL21] Flag raising by clear source
      if (match_a && mode != stm_pkg::STM_MODE_CAP) flag_a_d = 1'b1;
      if (match_p && !((mode == stm_pkg::STM_MODE_CMP || mode == stm_pkg::STM_MODE_TMR)
                       && ctrl1_q[stm_pkg::STM_C1_CLRSRC])) flag_p_d = 1'b1;
    end
    if (cap_ev)
    begin
      cmpa_d   = count_q;
      flag_a_d = 1'b1;
    end
    if (mode == stm_pkg::STM_MODE_CMP)
    begin
      // [RL3] [RL13] Initial level on run rising edge
      if (run_rise)
        out_d = ctrl1_q[stm_pkg::STM_C1_INIT];
      // [RL8] [RL12] [RL23] Only A match acts on pin
      else if (run && tick && !pause && match_a)
        case (pf)
          stm_pkg::STM_PF_1: out_d = 1'b0;
          stm_pkg::STM_PF_2: out_d = 1'b1;
          stm_pkg::STM_PF_3: out_d = !out_q;
          default:           out_d = out_q;
        endcase
    end
    else if (mode == stm_pkg::STM_MODE_PWM)
      out_d = ctrl1_q[stm_pkg::STM_C1_INIT] ? pwm_lvl : !pwm_lvl;
    if (mode == stm_pkg::STM_MODE_PWM && pf == stm_pkg::STM_PF_3
        && run && tick && !pause && match_a)
      ctrl0_d[stm_pkg::STM_C0_RUN] = 1'b0;
    if (wr)
    begin
      if (sel_addr(paddr_in, stm_pkg::STM_OFS_CTRL0))  ctrl0_d = pwdata_in[7:0] & stm_pkg::STM_C0_MASK;
      if (sel_addr(paddr_in, stm_pkg::STM_OFS_CTRL1))  ctrl1_d = pwdata_in[7:0];
      if (sel_addr(paddr_in, stm_pkg::STM_OFS_PERIOD)) period_d = pwdata_in[7:0];
      if (sel_addr(paddr_in, stm_pkg::STM_OFS_CMPA) && !cap_ev) cmpa_d = pwdata_in[15:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl0_q    <= stm_pkg::STM_RST_CTRL0;
      ctrl1_q    <= stm_pkg::STM_RST_CTRL1;
      period_q   <= stm_pkg::STM_RST_PERIOD;
      cmpa_q     <= stm_pkg::STM_RST_CMPA;
      count_q    <= 16'h0000;
      flag_a_q   <= 1'b0;
      flag_p_q   <= 1'b0;
      out_q      <= 1'b0;
      run_prev_q <= 1'b0;
      div_q      <= 6'h00;
      hdiv_q     <= 6'h00;
      ext_sync_q <= 3'h0;
      cap_sync_q <= 3'h0;
      ext_lvl_q  <= 1'b0;
      cap_lvl_q  <= 1'b0;
      rdata_q    <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      ctrl0_q    <= ctrl0_d;
      ctrl1_q    <= ctrl1_d;
      period_q   <= period_d;
      cmpa_q     <= cmpa_d;
      count_q    <= count_d;
      flag_a_q   <= flag_a_d;
      flag_p_q   <= flag_p_d;
      out_q      <= out_d;
      run_prev_q <= run_prev_d;
      div_q      <= div_d;
      hdiv_q     <= hdiv_d;
      ext_sync_q <= {ext_sync_q[1:0], ext_clk_pin_in};
      cap_sync_q <= {cap_sync_q[1:0], capture_input_pin_in};
      ext_lvl_q  <= ext_lvl_d;
      cap_lvl_q  <= cap_lvl_d;
      rdata_q    <= rdata_d;
    end
  end

  // [RL14] [RL7] Inversion and pin release
  assign timer_output_pin_out     = out_q ^ ctrl1_q[stm_pkg::STM_C1_INV];
  assign timer_output_pin_oe_out  = (mode != stm_pkg::STM_MODE_TMR) && (mode != stm_pkg::STM_MODE_CAP);
  assign compare_a_match_flag_out = flag_a_q;
  assign compare_p_match_flag_out = flag_p_q;

  // [RL1] Clear on run start
  a_run_clears_count : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL1
    ce_in && run_rise |=> count_q == 16'h0000)
    else $error("count not cleared on run start");

  // [RL2] Hold while stopped
  a_stop_holds_count : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL2
    ce_in && !run && !run_prev_q |=> $stable(count_q))
    else $error("count moved while stopped");

  // [RL24] Hold while paused
  a_pause_holds : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL24
    ce_in && pause && !run_rise |=> $stable(count_q))
    else $error("count moved while paused");

  // [RL3] Initial pin level
  a_init_level : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL3
    ce_in && run_rise && mode == stm_pkg::STM_MODE_CMP
    |=> out_q == $past(ctrl1_q[stm_pkg::STM_C1_INIT]))
    else $error("pin not at initial level");

  // [RL4] Unimplemented bits zero
  a_low_bits_zero : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL4
    ctrl0_q[2:0] == 3'h0)
    else $error("unimplemented bits set");

  // [RL7] Pin released
  a_pin_released : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL7
    mode == stm_pkg::STM_MODE_TMR |-> !timer_output_pin_oe_out)
    else $error("pin driven in timer mode");

  // [RL21] No P flag
  a_no_p_flag : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL21
    ce_in && mode == stm_pkg::STM_MODE_CMP && ctrl1_q[stm_pkg::STM_C1_CLRSRC] && !flag_p_q
    && !(wr && sel_addr(paddr_in, stm_pkg::STM_OFS_CTRL1)) |=> !flag_p_q)
    else $error("P flag with clear source A");

  // [RL14] Pin polarity
  a_invert_pin : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL14
    timer_output_pin_out == (out_q ^ ctrl1_q[stm_pkg::STM_C1_INV]))
    else $error("pin polarity wrong");

  // [RL9] PWM drives pin
  a_pwm_drives : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL9
    mode == stm_pkg::STM_MODE_PWM |-> timer_output_pin_oe_out)
    else $error("pin not driven in PWM mode");

  // [RL26] One step per tick
  a_count_step : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL26
    ce_in && run && run_prev_q && !pause && tick && !clr_cnt && !ovf
    |=> count_q == $past(count_q) + 16'h0001)
    else $error("count did not step");

  // [RL16] Clear on A match
  a_clear_on_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL16
    ce_in && run && !pause && tick && match_a && mode == stm_pkg::STM_MODE_CMP
    && ctrl1_q[stm_pkg::STM_C1_CLRSRC] |=> count_q == 16'h0000)
    else $error("count not cleared by A match");

  // [RL19] Clear on P match
  a_clear_on_p : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL19
    ce_in && run && !pause && tick && match_p && mode == stm_pkg::STM_MODE_CMP
    && !ctrl1_q[stm_pkg::STM_C1_CLRSRC] |=> count_q == 16'h0000)
    else $error("count not cleared by P match");

  // [RL17] Full wrap
  a_wrap_full : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL17
    ce_in && run && run_prev_q && !pause && tick && count_q == 16'hFFFF
    && period_q == 8'h00 |=> count_q == 16'h0000)
    else $error("count did not wrap");

  // [RL20] P flag raised
  a_p_flag_set : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL20
    ce_in && run && !pause && tick && match_p && mode == stm_pkg::STM_MODE_CMP
    && !ctrl1_q[stm_pkg::STM_C1_CLRSRC] |=> flag_p_q)
    else $error("P flag not raised");

  // [RL20] A flag raised
  a_a_flag_set : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL20
    ce_in && run && !pause && tick && match_a && mode == stm_pkg::STM_MODE_CMP
    |=> flag_a_q)
    else $error("A flag not raised");

  // [RL8] Toggle on A match
  a_toggle_pin : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL8
    ce_in && mode == stm_pkg::STM_MODE_CMP && run && run_prev_q && !pause && tick
    && match_a && pf == stm_pkg::STM_PF_3 |=> out_q != $past(out_q))
    else $error("pin did not toggle");

  // [RL23] Pin kept without A match
  a_pin_kept : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL23
    ce_in && mode == stm_pkg::STM_MODE_CMP && run_prev_q && !match_a
    |=> $stable(out_q))
    else $error("pin moved without A match");

  // [RL10] Capture latch
  a_capture_latch : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL10
    ce_in && cap_ev |=> cmpa_q == $past(count_q) && flag_a_q)
    else $error("capture not latched");

  // [RL15] Swapped period clear
  a_swap_clear : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL15
    ce_in && mode == stm_pkg::STM_MODE_PWM && ctrl1_q[stm_pkg::STM_C1_SWAP] && run
    && run_prev_q && !pause && tick && match_a |=> count_q == 16'h0000)
    else $error("swapped period not cleared");

  // [RL13] Forced active level
  a_pwm_active : assert property (@(posedge clk_in) disable iff (!rst_n_in) // RL13
    ce_in && mode == stm_pkg::STM_MODE_PWM && pf == stm_pkg::STM_PF_1
    |=> out_q == $past(ctrl1_q[stm_pkg::STM_C1_INIT]))
    else $error("PWM active level wrong");
endmodule : stm_timer

// ==== stm_pin_model.sv ====
// Purpose: Model of the circuitry on the timer's external clock and capture pins
// Assumes: Commands come from the bench on clk_in
// Notes:   External clock stands still low while not enabled
`timescale 1ns/1ps
module stm_pin_model
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ext_en_in,
  input  wire logic cap_lvl_in,
  output logic      ext_clk_pin_out,
  output logic      capture_input_pin_out
);
  logic [1:0] div_q;
  // Eight-cycle external clock in bursts
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_q                 <= 2'h0;
      ext_clk_pin_out       <= 1'b0;
      capture_input_pin_out <= 1'b0;
    end
    else
    begin
      capture_input_pin_out <= cap_lvl_in;
      div_q                 <= ext_en_in ? div_q + 2'h1 : 2'h0;
      if (!ext_en_in)
        ext_clk_pin_out <= 1'b0;
      else if (div_q == 2'h3)
        ext_clk_pin_out <= !ext_clk_pin_out;
    end
  end
endmodule : stm_pin_model

// ==== stm_timer_tb.sv ====
// Purpose: Self-checking bench of the timer control and compare-match block
// Assumes: APB answers in the first access cycle; counter clocked by fsys except in the external clock checks
// Notes:   Mode and pin function are changed only with the timer stopped
`timescale 1ns/1ps
module stm_timer_tb;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} stm_row_s;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic        ext_en = 1'b0;
  logic        cap_lvl = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, ext_pin, cap_pin, pin, oe, aflag, pflag;
  logic [31:0] rdata, c;
  logic        rerr;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n;
  stm_row_s    rows [6] = '{
    '{stm_pkg::STM_OFS_CTRL1, 32'hA5, 32'hA5, 1'b0},
    '{stm_pkg::STM_OFS_PERIOD, 32'h15A, 32'h5A, 1'b0},
    '{stm_pkg::STM_OFS_CMPA, 32'h1BEEF, 32'hBEEF, 1'b0},
    '{stm_pkg::STM_OFS_COUNT, 32'h1234, 32'h0, 1'b0},
    '{12'h020, 32'h55, 32'h0, 1'b1},
    '{stm_pkg::STM_OFS_CTRL0, 32'hFF, 32'hF8, 1'b0}};
  always #20 clk_in = !clk_in;
  stm_timer i_stm_timer (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .hs_tick_in(1'b0), .sub_tick_in(1'b0),
    .ext_clk_pin_in(ext_pin), .capture_input_pin_in(cap_pin), .timer_output_pin_out(pin),
    .timer_output_pin_oe_out(oe), .compare_a_match_flag_out(aflag),
    .compare_p_match_flag_out(pflag));
  stm_pin_model i_stm_pin_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .ext_en_in(ext_en),
    .cap_lvl_in(cap_lvl), .ext_clk_pin_out(ext_pin), .capture_input_pin_out(cap_pin));
  task automatic wrap_up();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rdata      = prdata_out;
    rerr       = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    #1;
  endtask : apb
  function automatic logic [31:0] c1(logic [1:0] m, logic [1:0] f, logic i, logic v, logic r);
    return {24'h0, m, f, i, v, 1'b0, r};
  endfunction : c1
  task automatic go(input logic [31:0] ctl);
    apb(1'b1, stm_pkg::STM_OFS_CTRL0, 32'h10);
    apb(1'b1, stm_pkg::STM_OFS_CTRL1, ctl);
    apb(1'b1, stm_pkg::STM_OFS_FLAGS, 32'h3);
    apb(1'b1, stm_pkg::STM_OFS_CTRL0, 32'h18);
    repeat (2) @(posedge clk_in);
    #1;
  endtask : go
  task automatic wait_fl(input logic p);
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    while ((p ? pflag : aflag) !== 1'b1 && n < 400);
  endtask : wait_fl
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset value", rdata, 32'h0);
    end
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      chk("register", rdata, rows[i].r);
      chk("slverr", {31'h0, rerr}, {31'h0, rows[i].e});
    end
    apb(1'b1, stm_pkg::STM_OFS_CMPA, 32'h20);
    apb(1'b1, stm_pkg::STM_OFS_PERIOD, 32'h0);
    go(c1(stm_pkg::STM_MODE_CMP, stm_pkg::STM_PF_3, 1'b1, 1'b0, 1'b1));
    chk("pin initial", {31'h0, pin}, 32'h1);
    wait_fl(1'b0);
    chk("pin toggled", {31'h0, pin}, 32'h0);
    chk("p flag", {31'h0, pflag}, 32'h0);
    apb(1'b1, stm_pkg::STM_OFS_CTRL0, 32'h10);
    apb(1'b0, stm_pkg::STM_OFS_COUNT, 32'h0);
    c = rdata;
    repeat (20) @(posedge clk_in);
    apb(1'b0, stm_pkg::STM_OFS_COUNT, 32'h0);
    chk("count held", rdata, c);
    apb(1'b1, stm_pkg::STM_OFS_CTRL0, 32'h18);
    apb(1'b0, stm_pkg::STM_OFS_COUNT, 32'h0);
    chk("count restarted", {31'h0, rdata < 32'h10}, 32'h1);
    chk("pin restored", {31'h0, pin}, 32'h1);
    go(c1(stm_pkg::STM_MODE_CMP, stm_pkg::STM_PF_2, 1'b1, 1'b0, 1'b1));
    wait_fl(1'b0);
    chk("pin same level", {31'h0, pin}, 32'h1);
    go(c1(stm_pkg::STM_MODE_CMP, stm_pkg::STM_PF_2, 1'b0, 1'b1, 1'b1));
    chk("pin inverted", {31'h0, pin}, 32'h1);
    wait_fl(1'b0);
    chk("pin inverted high", {31'h0, pin}, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      go(c1(stm_pkg::STM_MODE_PWM, 2'(k >> 1), k[0], 1'b0, 1'b0));
      repeat (2) @(posedge clk_in);
      #1;
      chk("pwm forced", {31'h0, pin}, {31'h0, k[0] ^ (k < 2)});
    end
    apb(1'b1, stm_pkg::STM_OFS_CMPA, 32'h40);
    apb(1'b1, stm_pkg::STM_OFS_PERIOD, 32'h1);
    go(c1(stm_pkg::STM_MODE_CMP, stm_pkg::STM_PF_3, 1'b1, 1'b0, 1'b0));
    wait_fl(1'b0);
    apb(1'b1, stm_pkg::STM_OFS_FLAGS, 32'h3);
    wait_fl(1'b1);
    chk("pin at p match", {31'h0, pin}, 32'h0);
    apb(1'b1, stm_pkg::STM_OFS_FLAGS, 32'h3);
    wait_fl(1'b1);
    chk("p period", {31'h0, n >= 245 && n <= 262}, 32'h1);
    chk("a flag too", {31'h0, aflag}, 32'h1);
    for (int m = 0; m < 4; m++)
    begin
      go(c1(2'(m), stm_pkg::STM_PF_0, 1'b1, 1'b1, 1'b0));
      chk("pin enable", {31'h0, oe}, {31'h0, m == 0 || m == 2});
    end
    for (int f = 0; f < 4; f++)
    begin
      go(c1(stm_pkg::STM_MODE_CAP, 2'(f), 1'b0, 1'b0, 1'b0));
      @(posedge clk_in);
      cap_lvl <= 1'b1;
      repeat (8) @(posedge clk_in);
      #1;
      chk("capture rise", {31'h0, aflag}, {31'h0, f == 0 || f == 2});
      @(posedge clk_in);
      cap_lvl <= 1'b0;
      repeat (8) @(posedge clk_in);
      #1;
      chk("capture fall", {31'h0, aflag}, {31'h0, f != 3});
    end
    go(c1(stm_pkg::STM_MODE_TMR, stm_pkg::STM_PF_0, 1'b0, 1'b0, 1'b0));
    apb(1'b1, stm_pkg::STM_OFS_CTRL0, 32'h98);
    apb(1'b0, stm_pkg::STM_OFS_COUNT, 32'h0);
    c = rdata;
    repeat (10) @(posedge clk_in);
    apb(1'b0, stm_pkg::STM_OFS_COUNT, 32'h0);
    chk("paused", rdata, c);
    apb(1'b1, stm_pkg::STM_OFS_CTRL0, 32'h18);
    apb(1'b0, stm_pkg::STM_OFS_COUNT, 32'h0);
    chk("resumed", {31'h0, rdata > c && rdata < c + 16}, 32'h1);
    ext_en <= 1'b1;
    for (int e = 6; e < 8; e++)
    begin
      apb(1'b1, stm_pkg::STM_OFS_CTRL0, 32'(e << 4));
      apb(1'b1, stm_pkg::STM_OFS_CTRL0, 32'(e << 4) | 32'h8);
      repeat (160) @(posedge clk_in);
      apb(1'b0, stm_pkg::STM_OFS_COUNT, 32'h0);
      chk("ext count", {31'h0, rdata >= 18 && rdata <= 22}, 32'h1);
    end
    ext_en <= 1'b0;
    wrap_up();
  end
endmodule : stm_timer_tb
